/* File: verilog/nvs_cfg.svh */
`ifndef NVS_CFG_SVH
`define NVS_CFG_SVH

// bus and timer widths
`define NVS_ADDR_W        17
`define NVS_DATA_W        8
`define NVS_TIMER_W       20

// clock period
`define NVS_CLK_NS        40

// array cycle: strobe low time covers the slowest speed grade
`define NVS_T_ACC_NS      45
`define NVS_ACC_CYC       ((`NVS_T_ACC_NS + `NVS_CLK_NS - 1) / `NVS_CLK_NS)

// hardware save request pulse, least width
`define NVS_T_HSB_NS      15
`define NVS_HSB_CYC       ((`NVS_T_HSB_NS + `NVS_CLK_NS - 1) / `NVS_CLK_NS)

// device-side durations, all waited in full
`define NVS_T_SS_US       70
`define NVS_SS_CYC        ((`NVS_T_SS_US * 1000 + `NVS_CLK_NS - 1) / `NVS_CLK_NS)
`define NVS_T_DELAY_US    70
`define NVS_DELAY_CYC     ((`NVS_T_DELAY_US * 1000 + `NVS_CLK_NS - 1) / `NVS_CLK_NS)
`define NVS_T_RECALL_US   100
`define NVS_RECALL_CYC    ((`NVS_T_RECALL_US * 1000 + `NVS_CLK_NS - 1) / `NVS_CLK_NS)
`define NVS_T_STORE_US    15000
`define NVS_T_HRECALL_US  20000

// six-read command sequence; last entry selects save or restore
`define NVS_SEQ_0         17'h00000
`define NVS_SEQ_1         17'h00001
`define NVS_SEQ_2         17'h00002
`define NVS_SEQ_3         17'h00003
`define NVS_SEQ_4         17'h00004
`define NVS_SEQ_STORE     17'h00005
`define NVS_SEQ_RECALL    17'h00006
`define NVS_SEQ_LAST      3'h5

`endif

/* File: verilog/nvs_pkg.sv */
package nvs_pkg;

	// host command kinds
	typedef enum logic [2:0]
	{
		NVS_CMD_READ      = 3'h0,
		NVS_CMD_WRITE     = 3'h1,
		NVS_CMD_SW_STORE  = 3'h2,
		NVS_CMD_SW_RECALL = 3'h3,
		NVS_CMD_HW_STORE  = 3'h4
	} nvs_cmd_t;

	// controller states
	typedef enum logic [2:0]
	{
		NVS_ST_PWRUP     = 3'h0,
		NVS_ST_IDLE      = 3'h1,
		NVS_ST_SETUP     = 3'h2,
		NVS_ST_STROBE    = 3'h3,
		NVS_ST_GAP       = 3'h4,
		NVS_ST_HSB_PULSE = 3'h5,
		NVS_ST_OP_WAIT   = 3'h6
	} nvs_state_t;

endpackage

/* File: verilog/nvs_timer.sv */
`timescale 1ns/1ps
`include "nvs_cfg.svh"

// down counter; expired is high while the count rests at zero
module nvs_timer
#(
	parameter logic [`NVS_TIMER_W-1:0] RESET_COUNT = 20'h00000
)
(
	input  wire logic                    clock,
	input  wire logic                    rst,
	input  wire logic                    load,
	input  wire logic [`NVS_TIMER_W-1:0] load_value,
	output logic                         expired
);

	logic [`NVS_TIMER_W-1:0] count;

	// load wins over counting so a new wait always starts cleanly
	always_ff @(posedge clock)
	begin
		if (rst)
			count <= RESET_COUNT;
		else if (load)
			count <= load_value;
		else if (count != 20'h00000)
			count <= count - 20'h00001;
	end

	assign expired = (count == 20'h00000);

endmodule

/* File: verilog/nvs_host.sv */
`timescale 1ns/1ps
`include "nvs_cfg.svh"

// Datasheet rules this block is built on
// R1 - device skips a save when nothing was written since the last one
// R2 - outputs stay off if write strobe is low when select falls
// R3 - write strobe stays high through every read cycle
// R4 - command is six consecutive reads of fixed addresses, write strobe high
// R5 - each command step is a select-controlled or output-strobe-controlled read
// R6 - device acts on a command within 70 us of the last read
// R7 - device locks out all accesses while save or restore runs
// R8 - save finishes within 12.5 ms commercial, 15 ms industrial
// R9 - power-up restore finishes within 20 ms of supply rising
// R10 - device lets a running cycle finish for up to 70 us before saving
// R11 - hardware save request is a low pulse of at least 15 ns
// R12 - host holds off traffic for the worst-case save or restore time
module nvs_host
	import nvs_pkg::*;
#(
	parameter int unsigned STORE_CYC = (`NVS_T_STORE_US * 1000) / `NVS_CLK_NS,
	parameter int unsigned PWRUP_CYC = (`NVS_T_HRECALL_US * 1000) / `NVS_CLK_NS
)
(
	input  wire logic                   clock,
	input  wire logic                   rst,
	input  wire logic                   cmd_valid,
	input  wire nvs_pkg::nvs_cmd_t      cmd_kind,
	input  wire logic [`NVS_ADDR_W-1:0] cmd_addr,
	input  wire logic [`NVS_DATA_W-1:0] cmd_wdata,
	output logic                        cmd_ready,
	output logic                        rsp_valid,
	output logic [`NVS_DATA_W-1:0]      rsp_rdata,
	output logic                        op_busy,
	output logic [`NVS_ADDR_W-1:0]      mem_addr,
	output logic                        mem_cs_n,
	output logic                        mem_we_n,
	output logic                        mem_oe_n,
	output logic [`NVS_DATA_W-1:0]      mem_dq_out,
	output logic                        mem_dq_oe,
	input  wire logic [`NVS_DATA_W-1:0] mem_dq_in,
	input  wire logic                   hardware_store_busy_n_in,
	output logic                        hardware_store_busy_n_out,
	output logic                        hardware_store_busy_n_oe
);

	import nvs_pkg::*;

	nvs_state_t              state;
	nvs_cmd_t                kind;
	logic [2:0]              seq_idx;
	logic                    timer_load;
	logic [`NVS_TIMER_W-1:0] timer_value;
	logic                    timer_expired;
	logic                    is_sw;
	logic                    is_write;

	// command address for each step of the six-read sequence
	function automatic logic [`NVS_ADDR_W-1:0] seq_addr(input logic [2:0] idx,
		input nvs_cmd_t k);
		logic [`NVS_ADDR_W-1:0] a;
		begin
			a = `NVS_SEQ_0;
			case (idx)
				3'h0: a = `NVS_SEQ_0;
				3'h1: a = `NVS_SEQ_1;
				3'h2: a = `NVS_SEQ_2;
				3'h3: a = `NVS_SEQ_3;
				3'h4: a = `NVS_SEQ_4;
				default: a = (k == NVS_CMD_SW_STORE) ? `NVS_SEQ_STORE : `NVS_SEQ_RECALL;
			endcase
			return a;
		end
	endfunction

	assign is_sw    = (kind == NVS_CMD_SW_STORE) || (kind == NVS_CMD_SW_RECALL);
	assign is_write = (kind == NVS_CMD_WRITE);

	// every wait in the block shares one counter; states never overlap
	always_comb
	begin
		timer_load  = 1'b0;
		timer_value = 20'h00000;
		case (state)
			NVS_ST_IDLE:
			begin
				if (cmd_valid && cmd_kind == NVS_CMD_HW_STORE)
				begin
					timer_load  = 1'b1;
					timer_value = 20'(`NVS_HSB_CYC); // R11
				end
			end
			NVS_ST_SETUP:
			begin
				timer_load  = 1'b1;
				timer_value = 20'(`NVS_ACC_CYC);
			end
			NVS_ST_GAP:
			begin
				if (is_sw && seq_idx == `NVS_SEQ_LAST)
				begin
					timer_load = 1'b1;
					// R6 R8 R12
					if (kind == NVS_CMD_SW_STORE)
						timer_value = 20'(`NVS_SS_CYC + STORE_CYC);
					else
						timer_value = 20'(`NVS_SS_CYC + `NVS_RECALL_CYC);
				end
			end
			NVS_ST_HSB_PULSE:
			begin
				if (timer_expired)
				begin
					timer_load  = 1'b1;
					timer_value = 20'(`NVS_DELAY_CYC + STORE_CYC); // R10 R8 R12
				end
			end
			default:
			begin
				timer_load  = 1'b0;
				timer_value = 20'h00000;
			end
		endcase
	end

	// reset value holds traffic off until the power-up restore is over
	nvs_timer
	#(
		.RESET_COUNT (20'(PWRUP_CYC))
	)
	u_timer
	(
		.clock      (clock),
		.rst        (rst),
		.load       (timer_load),
		.load_value (timer_value),
		.expired    (timer_expired)
	); // R9

	// sequencer and pin drive
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state                     <= NVS_ST_PWRUP;
			kind                      <= NVS_CMD_READ;
			seq_idx                   <= 3'h0;
			cmd_ready                 <= 1'b0;
			rsp_valid                 <= 1'b0;
			rsp_rdata                 <= 8'h00;
			op_busy                   <= 1'b1;
			mem_addr                  <= 17'h00000;
			mem_cs_n                  <= 1'b1;
			mem_we_n                  <= 1'b1;
			mem_oe_n                  <= 1'b1;
			mem_dq_out                <= 8'h00;
			mem_dq_oe                 <= 1'b0;
			hardware_store_busy_n_out <= 1'b0;
			hardware_store_busy_n_oe  <= 1'b0;
		end
		else
		begin
			rsp_valid <= 1'b0;
			case (state)
				NVS_ST_PWRUP:
				begin
					// also wait for the device to release its busy line
					if (timer_expired && hardware_store_busy_n_in)
					begin
						state     <= NVS_ST_IDLE;
						cmd_ready <= 1'b1;
						op_busy   <= 1'b0;
					end
				end
				NVS_ST_IDLE:
				begin
					if (cmd_valid)
					begin
						cmd_ready <= 1'b0;
						kind      <= cmd_kind;
						seq_idx   <= 3'h0;
						if (cmd_kind == NVS_CMD_HW_STORE)
						begin
							op_busy                  <= 1'b1;
							hardware_store_busy_n_oe <= 1'b1; // R11
							state                    <= NVS_ST_HSB_PULSE;
						end
						else
						begin
							// address and data settle with all strobes high
							if (cmd_kind == NVS_CMD_SW_STORE || cmd_kind == NVS_CMD_SW_RECALL)
								mem_addr <= seq_addr(3'h0, cmd_kind); // R4
							else
								mem_addr <= cmd_addr;
							mem_dq_out <= cmd_wdata;
							mem_dq_oe  <= (cmd_kind == NVS_CMD_WRITE);
							state      <= NVS_ST_SETUP;
						end
					end
				end
				NVS_ST_SETUP:
				begin
					// select and strobe fall together, so a read never sees a write edge
					mem_cs_n <= 1'b0; // R5
					mem_we_n <= !is_write; // R3 R2
					mem_oe_n <= is_write; // R5
					state    <= NVS_ST_STROBE;
				end
				NVS_ST_STROBE:
				begin
					if (timer_expired)
					begin
						mem_cs_n <= 1'b1;
						mem_we_n <= 1'b1;
						mem_oe_n <= 1'b1;
						if (kind == NVS_CMD_READ)
						begin
							rsp_rdata <= mem_dq_in;
							rsp_valid <= 1'b1;
						end
						state <= NVS_ST_GAP;
					end
				end
				NVS_ST_GAP:
				begin
					// data held one cycle past the write strobe rising
					mem_dq_oe <= 1'b0;
					if (is_sw && seq_idx != `NVS_SEQ_LAST)
					begin
						seq_idx  <= seq_idx + 3'h1;
						mem_addr <= seq_addr(seq_idx + 3'h1, kind); // R4
						state    <= NVS_ST_SETUP;
					end
					else if (is_sw)
					begin
						op_busy <= 1'b1; // R7
						state   <= NVS_ST_OP_WAIT;
					end
					else
					begin
						cmd_ready <= 1'b1;
						state     <= NVS_ST_IDLE;
					end
				end
				NVS_ST_HSB_PULSE:
				begin
					if (timer_expired)
					begin
						hardware_store_busy_n_oe <= 1'b0;
						state                    <= NVS_ST_OP_WAIT;
					end
				end
				NVS_ST_OP_WAIT:
				begin
					// a skipped save ends early inside the device; the full wait is kept
					if (timer_expired && hardware_store_busy_n_in) // R12 R7 R1
					begin
						op_busy   <= 1'b0;
						cmd_ready <= 1'b1;
						state     <= NVS_ST_IDLE;
					end
				end
				default:
				begin
					state <= NVS_ST_IDLE;
				end
			endcase
		end
	end

endmodule

/* File: verif/nvs_host_checker.sv */
`timescale 1ns/1ps
`include "nvs_cfg.svh"

// watches the host pins for strobe order, lockout and save pulse rules
module nvs_host_checker
	import nvs_pkg::*;
#(
	parameter int unsigned PWRUP_CYC = 20
)
(
	input wire logic                   clock,
	input wire logic                   rst,
	input wire logic                   cmd_valid,
	input wire nvs_pkg::nvs_cmd_t      cmd_kind,
	input wire logic                   cmd_ready,
	input wire logic                   rsp_valid,
	input wire logic                   op_busy,
	input wire logic [`NVS_ADDR_W-1:0] mem_addr,
	input wire logic                   mem_cs_n,
	input wire logic                   mem_we_n,
	input wire logic                   mem_oe_n,
	input wire logic                   hardware_store_busy_n_out,
	input wire logic                   hardware_store_busy_n_oe
);
	int unsigned busy_cnt;

	default clocking @(posedge clock); endclocking
	default disable iff (rst);

	// busy run length; saturates so a long wait never wraps
	always_ff @(posedge clock)
	begin
		if (rst || !op_busy)
			busy_cnt <= 32'h0;
		else if (busy_cnt < 32'h00FFFFFF)
			busy_cnt <= busy_cnt + 32'h1;
	end

	sequence s_take_rd;
		cmd_valid && cmd_ready && cmd_kind == NVS_CMD_READ;
	endsequence
	// strobes go low at setup and rise on the edge the two-count wait expires
	sequence s_strobe;
		!mem_cs_n [*3] ##1 mem_cs_n;
	endsequence
	// one-count wait plus the expiry edge keeps the pull two cycles long
	sequence s_pulse;
		op_busy ##1 hardware_store_busy_n_oe ##1 !hardware_store_busy_n_oe;
	endsequence

	AST_RD_WE: assert property (!mem_oe_n |-> mem_we_n)
		else $error("write strobe low in a read");
	AST_RSP: assert property (s_take_rd |-> ##[3:5] rsp_valid)
		else $error("read answer missing");
	AST_STROBE: assert property ($fell(mem_cs_n) |-> s_strobe)
		else $error("strobe low time wrong");
	AST_ADDR: assert property (!mem_cs_n |-> $stable(mem_addr))
		else $error("address moved under select");
	AST_WE_ORDER: assert property ($fell(mem_cs_n) |-> $past(mem_we_n))
		else $error("write strobe low before select");
	AST_LOCK: assert property (op_busy |-> mem_cs_n && !cmd_ready)
		else $error("access during busy");
	AST_HSB: assert property ($rose(hardware_store_busy_n_oe) |-> s_pulse)
		else $error("save pulse shape wrong");
	AST_OD: assert property (hardware_store_busy_n_oe |-> !hardware_store_busy_n_out)
		else $error("busy line driven high");
	AST_WAIT: assert property ($fell(op_busy) |-> busy_cnt >= PWRUP_CYC - 1)
		else $error("busy wait too short");
endmodule

bind nvs_host nvs_host_checker #(.PWRUP_CYC(PWRUP_CYC)) u_chk (.*);

/* File: verif/nvs_dev_model.sv */
`timescale 1ns/1ps

// array with a nonvolatile copy; pulls busy low while an operation runs
module nvs_dev_model
(
	input wire logic        clock,
	input wire logic [16:0] addr,
	input wire logic        cs_n,
	input wire logic        we_n,
	input wire logic        oe_n,
	input wire logic [7:0]  dq_in,
	output logic [7:0]      dq_out,
	input wire logic        busy_line,
	output logic            busy_oe
);
	logic [7:0] mem [0:131071];
	logic [7:0] nv [0:131071];
	logic [7:0] last = 8'h00;
	logic       prev_cs = 1'b1;
	logic       prev_busy = 1'b1;
	logic       we_fall = 1'b0;
	logic       dirty = 1'b0;
	int         step = 0;
	int         left = 0;
	int         op_cyc = 30;
	int         n_store = 0;

	// skipped when clean, so no busy is shown then
	task automatic save;
		if (dirty)
		begin
			for (int i = 0; i < 131072; i++)
				nv[i] = mem[i];
			dirty = 1'b0;
			left = op_cyc;
			n_store++;
		end
	endtask

	assign busy_oe = left > 0;
	// garbage off the read window so a stale byte never passes
	assign dq_out = (!cs_n && !oe_n && we_n && we_fall && left == 0) ? mem[addr] : ~last;

	// array, six-read decoder and save triggers
	always @(posedge clock)
	begin
		prev_cs <= cs_n;
		prev_busy <= busy_line;
		last <= dq_out;
		if (left > 0)
			left <= left - 1;
		else if (!cs_n && !we_n)
		begin
			mem[addr] <= dq_in;
			dirty <= 1'b1;
		end
		else if (prev_busy && !busy_line)
			save();
		if (prev_cs && !cs_n)
		begin
			we_fall <= we_n;
			if (!we_n || left > 0)
				step <= 0;
			else if (step < 5)
				step <= (addr == step) ? step + 1 : int'(addr == 0);
			else
			begin
				step <= 0;
				if (addr == 5)
					save();
				if (addr == 6)
				begin
					for (int i = 0; i < 131072; i++)
						mem[i] = nv[i];
					left = op_cyc;
				end
			end
		end
	end
endmodule

/* File: verif/nvs_host_tb.sv */
`timescale 1ns/1ps
`include "nvs_cfg.svh"

module nvs_host_tb;
	import nvs_pkg::*;
	localparam int SC = 40;
	logic        clock = 1'b0, rst = 1'b1, cmd_valid = 1'b0;
	nvs_cmd_t    cmd_kind = NVS_CMD_READ;
	logic [16:0] cmd_addr = 17'h00000, mem_addr;
	logic [7:0]  cmd_wdata = 8'h00, rsp_rdata, mem_dq_out, mem_dq_in, dev_dq;
	logic        cmd_ready, rsp_valid, op_busy, mem_cs_n, mem_we_n, mem_oe_n, mem_dq_oe;
	logic        hardware_store_busy_n_in, hardware_store_busy_n_out;
	logic        hardware_store_busy_n_oe, dev_oe;
	int          failures = 0, checks = 0;

	// shared data bus and pulled-up busy line
	assign mem_dq_in = mem_dq_oe ? mem_dq_out : dev_dq;
	assign hardware_store_busy_n_in = !((hardware_store_busy_n_oe && !hardware_store_busy_n_out)
		|| dev_oe);
	always #20 clock = ~clock;

	nvs_host #(.STORE_CYC(SC), .PWRUP_CYC(20)) uut (.*);
	nvs_dev_model dev (.clock(clock), .addr(mem_addr), .cs_n(mem_cs_n), .we_n(mem_we_n),
		.oe_n(mem_oe_n), .dq_in(mem_dq_in), .dq_out(dev_dq),
		.busy_line(hardware_store_busy_n_in), .busy_oe(dev_oe));

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e)
		begin
			failures++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask

	task test_done;
		if (failures == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// one command; n counts cycles from take until ready again
	task automatic cmd(input nvs_cmd_t k, input logic [16:0] a, input logic [7:0] d,
		output logic [7:0] q, output int n);
		n = 0;
		q = 8'h00;
		while (cmd_ready !== 1'b1 && n < 9000)
		begin
			@(negedge clock);
			n++;
		end
		@(posedge clock);
		cmd_valid <= 1'b1;
		cmd_kind <= k;
		cmd_addr <= a;
		cmd_wdata <= d;
		@(posedge clock);
		cmd_valid <= 1'b0;
		n = 0;
		do
		begin
			@(negedge clock);
			n++;
			if (rsp_valid === 1'b1)
				q = rsp_rdata;
		end while (cmd_ready !== 1'b1 && n < 9000);
		chk("cmd_ready", 1, cmd_ready);
	endtask

	task automatic t_reset;
		int n;
		n = 0;
		@(negedge clock);
		chk("op_busy", 1, op_busy);
		chk("cmd_ready", 0, cmd_ready);
		chk("mem_cs_n", 1, mem_cs_n);
		chk("busy_oe", 0, hardware_store_busy_n_oe);
		while (cmd_ready !== 1'b1 && n < 100)
		begin
			@(negedge clock);
			n++;
		end
		chk("pwrup_ready", 1, cmd_ready);
		chk("pwrup_wait", 1, n >= 20);
	endtask

	task automatic t_rw;
		logic [7:0] q;
		int n;
		cmd(NVS_CMD_WRITE, 17'h00000, 8'hA5, q, n);
		cmd(NVS_CMD_WRITE, 17'h1FFFF, 8'h5A, q, n);
		cmd(NVS_CMD_READ, 17'h1FFFF, 8'h00, q, n);
		chk("rd_top", 8'h5A, q);
		cmd(NVS_CMD_READ, 17'h00000, 8'h00, q, n);
		chk("rd_zero", 8'hA5, q);
	endtask

	// save, then a clean save the device skips, then restore
	task automatic t_soft;
		logic [7:0] q;
		int n, s;
		cmd(NVS_CMD_WRITE, 17'h00100, 8'h55, q, n);
		cmd(NVS_CMD_SW_STORE, 17'h00000, 8'h00, q, n);
		chk("store_wait", 1, n >= `NVS_SS_CYC + SC);
		chk("nv_byte", 8'h55, dev.nv[256]);
		s = dev.n_store;
		cmd(NVS_CMD_SW_STORE, 17'h00000, 8'h00, q, n);
		chk("skip_store", s, dev.n_store);
		cmd(NVS_CMD_WRITE, 17'h00100, 8'hAA, q, n);
		cmd(NVS_CMD_SW_RECALL, 17'h00000, 8'h00, q, n);
		chk("recall_wait", 1, n >= `NVS_SS_CYC + `NVS_RECALL_CYC);
		cmd(NVS_CMD_READ, 17'h00100, 8'h00, q, n);
		chk("rd_recall", 8'h55, q);
	endtask

	// slow device: host must wait for the busy line too
	task automatic t_hw;
		logic [7:0] q;
		int n;
		cmd(NVS_CMD_WRITE, 17'h00200, 8'h3C, q, n);
		dev.op_cyc = 3000;
		cmd(NVS_CMD_HW_STORE, 17'h00000, 8'h00, q, n);
		chk("hw_wait", 1, n >= 3000);
		chk("hw_nv", 8'h3C, dev.nv[512]);
	endtask

	// main sequence
	initial
	begin
		repeat (8) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_rw();
		t_soft();
		t_hw();
		test_done();
	end

	// watchdog sized well past the longest run
	initial
	begin
		#(40 * 30000);
		$display("mismatch watchdog expected done seen timeout");
		failures++;
		test_done();
	end
endmodule
